/* File: logic/ict_pkg.sv */
// Constants, types and field layouts of the I2C interrupt-clear and timing block
// Function
// - Bit 3 one clears TX overrun pending
// - Bit 16 one clears slave-read request pending
// - Bit 17 one clears slave-read empty pending
// - Bit 18 one clears slave-write request pending
// - Bit 19 one clears master done pending
// - Bit 20 one clears slave done pending
// - Bit 24 one clears arbitration lost pending
// - Bit 25 one clears bus error pending
// - Bit 28 one clears master done nostop
// - SCL fall starts data hold count, then transfer
// - Standard start hold count, then SCL low
// - Fast start hold count, then SCL low
// - Standard setup count, then generate start
// - Fast setup count, then generate start
// - Clear bit acts on same-position status flag
`default_nettype none
package ict_pkg;
  localparam int ICT_AW = 8;
  localparam int ICT_CW = 9;
  // Register byte offsets
  localparam logic [7:0] ICT_OFF_IRQ_CLEAR = 8'h38;
  localparam logic [7:0] ICT_OFF_DATA_HOLD = 8'h4C;
  localparam logic [7:0] ICT_OFF_START_HOLD = 8'h50;
  localparam logic [7:0] ICT_OFF_START_SETUP = 8'h58;
  localparam logic [7:0] ICT_OFF_IRQ_STATUS = 8'h60;
  localparam logic [7:0] ICT_OFF_IRQ_MASK = 8'h64;
  localparam logic [7:0] ICT_OFF_CTRL = 8'h68;
  localparam logic [7:0] ICT_OFF_STATE = 8'h6C;
  // Interrupt bit positions
  localparam int ICT_B_TX_OVERRUN = 3;
  localparam int ICT_B_SLV_RD_REQ = 16;
  localparam int ICT_B_SLV_RD_EMPTY = 17;
  localparam int ICT_B_SLV_WR_REQ = 18;
  localparam int ICT_B_MST_DONE = 19;
  localparam int ICT_B_SLV_DONE = 20;
  localparam int ICT_B_ARB_LOST = 24;
  localparam int ICT_B_BUS_ERR = 25;
  localparam int ICT_B_MST_NOSTOP = 28;
  localparam logic [31:0] ICT_IRQ_BITS = 32'h131F_0008;
  // Timing field positions
  localparam int ICT_STD_LSB = 0;
  localparam int ICT_FST_LSB = 16;
  localparam int ICT_CTRL_START = 0;
  // Reset values
  localparam logic [8:0] ICT_RST_DATA_HOLD = 9'h014;
  localparam logic [8:0] ICT_RST_HOLD_STD = 9'h0E2;
  localparam logic [8:0] ICT_RST_HOLD_FST = 9'h03F;
  localparam logic [8:0] ICT_RST_SETUP_STD = 9'h0E2;
  localparam logic [8:0] ICT_RST_SETUP_FST = 9'h01D;
  localparam logic [31:0] ICT_RST_MASK = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ict_bus_req_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } ict_pin_drive_t;

  typedef enum logic [1:0] {
    ICT_ST_IDLE = 2'b00,
    ICT_ST_WAIT_HIGH = 2'b01,
    ICT_ST_SETUP = 2'b10,
    ICT_ST_HOLD = 2'b11
  } ict_state_t;
endpackage
`default_nettype wire

/* File: logic/ict_top.sv */
// I2C interrupt-clear register and start/data timing counters
`timescale 1ns/100ps
`default_nettype none
module ict_top (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // Register port
  input wire ict_pkg::ict_bus_req_t I_BUS,
  output logic [31:0] O_RDATA,
  // Controller side
  input wire logic [31:0] I_EVT,
  input wire logic I_FAST_MODE,
  input wire logic I_TX_EN,
  input wire logic I_TX_BIT,
  output logic O_DATA_XFER,
  output logic O_START_DONE,
  output logic O_IRQ,
  // I2C pins, open drain
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SCL_O,
  output logic O_SCL_OE,
  output logic O_SDA_O,
  output logic O_SDA_OE
);
  import ict_pkg::*;

  logic [31:0] pending;
  logic [31:0] mask;
  logic [8:0] data_hold_count;
  logic [8:0] start_hold_std_count;
  logic [8:0] start_hold_fast_count;
  logic [8:0] start_setup_std_count;
  logic [8:0] start_setup_fast_count;
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic scl_fall, start_det, bus_idle;
  logic [8:0] dh_cnt;
  logic dh_run, dh_hit;
  logic [8:0] st_cnt;
  logic st_hit;
  logic start_req;
  ict_state_t state;
  ict_pin_drive_t drive;
  logic wr_clear, wr_status;
  logic [31:0] clr_bits, evt_bits, next_pending;
  logic [8:0] hold_sel, setup_sel;

  function automatic logic [8:0] ict_pick(input logic fast, input logic [8:0] std_v,
                                          input logic [8:0] fst_v);
    ict_pick = fast ? fst_v : std_v;
  endfunction

  function automatic logic [8:0] ict_field(input logic [31:0] w, input int lsb);
    ict_field = w[lsb +: ICT_CW];
  endfunction

  // Pin synchronisers; the second stage feeds logic, and the third stage also feeds the edge detectors
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= I_SCL;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= I_SDA;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_fall = scl_d & ~scl_s;
  assign start_det = sda_d & ~sda_s & scl_s;
  assign bus_idle = scl_s & sda_s;

  // Register decode
  assign wr_clear = I_BUS.wr && (I_BUS.addr == ICT_OFF_IRQ_CLEAR);
  assign wr_status = I_BUS.wr && (I_BUS.addr == ICT_OFF_IRQ_STATUS);
  assign clr_bits = (wr_clear || wr_status) ? (I_BUS.wdata & ICT_IRQ_BITS) : 32'h0000_0000;
  assign evt_bits = I_EVT & ICT_IRQ_BITS;
  // Set wins over a clear in the same cycle, so no event is lost
  assign next_pending = (pending & ~clr_bits) | evt_bits;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pending <= 32'h0000_0000;
    end else begin
      pending <= next_pending;
    end
  end
  // Clear bits 3,16..20,24,25,28 act through clr_bits

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      mask <= ICT_RST_MASK;
    end else if (I_BUS.wr && I_BUS.addr == ICT_OFF_IRQ_MASK) begin
      mask <= I_BUS.wdata & ICT_IRQ_BITS;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(next_pending & mask);
    end
  end

  // Timing registers; reserved bits are not stored and read as zero
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      data_hold_count <= ICT_RST_DATA_HOLD;
      start_hold_std_count <= ICT_RST_HOLD_STD;
      start_hold_fast_count <= ICT_RST_HOLD_FST;
      start_setup_std_count <= ICT_RST_SETUP_STD;
      start_setup_fast_count <= ICT_RST_SETUP_FST;
    end else if (I_BUS.wr) begin
      case (I_BUS.addr)
        ICT_OFF_DATA_HOLD: begin
          data_hold_count <= ict_field(I_BUS.wdata, ICT_STD_LSB);
        end
        ICT_OFF_START_HOLD: begin
          start_hold_std_count <= ict_field(I_BUS.wdata, ICT_STD_LSB);
          start_hold_fast_count <= ict_field(I_BUS.wdata, ICT_FST_LSB);
        end
        ICT_OFF_START_SETUP: begin
          start_setup_std_count <= ict_field(I_BUS.wdata, ICT_STD_LSB);
          start_setup_fast_count <= ict_field(I_BUS.wdata, ICT_FST_LSB);
        end
        default: begin
        end
      endcase
    end
  end

  // Read data, valid in the cycle after the strobe
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_RDATA <= 32'h0000_0000;
    end else if (I_BUS.rd) begin
      case (I_BUS.addr)
        ICT_OFF_DATA_HOLD: O_RDATA <= {23'h0, data_hold_count};
        ICT_OFF_START_HOLD: O_RDATA <= {7'h00, start_hold_fast_count, 7'h00, start_hold_std_count};
        ICT_OFF_START_SETUP: O_RDATA <= {7'h00, start_setup_fast_count, 7'h00,
                                         start_setup_std_count};
        ICT_OFF_IRQ_STATUS: O_RDATA <= pending;
        ICT_OFF_IRQ_MASK: O_RDATA <= mask;
        ICT_OFF_CTRL: O_RDATA <= {31'h0, start_req};
        ICT_OFF_STATE: O_RDATA <= {26'h0, dh_run, drive.scl_oe, drive.sda_oe,
                                   I_FAST_MODE, state};
        default: O_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      O_RDATA <= 32'h0000_0000;
    end
  end

  // Mode picks the standard or fast figure; counts are in I_MCLK cycles
  assign hold_sel = ict_pick(I_FAST_MODE, start_hold_std_count, start_hold_fast_count);
  assign setup_sel = ict_pick(I_FAST_MODE, start_setup_std_count, start_setup_fast_count);

  // Data hold counter: restarted by every SCL fall, even a stretched one
  assign dh_hit = dh_run && (dh_cnt == data_hold_count);

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      dh_run <= 1'b0;
      dh_cnt <= 9'h000;
    end else if (scl_fall) begin
      dh_run <= 1'b1;
      dh_cnt <= 9'h000;
    end else if (dh_hit) begin
      dh_run <= 1'b0;
    end else if (dh_run) begin
      dh_cnt <= dh_cnt + 9'h001;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_DATA_XFER <= 1'b0;
    end else begin
      O_DATA_XFER <= dh_hit;
    end
  end

  // Start request is self clearing once the sequence is taken
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      start_req <= 1'b0;
    end else if (I_BUS.wr && I_BUS.addr == ICT_OFF_CTRL && I_BUS.wdata[ICT_CTRL_START]) begin
      start_req <= 1'b1;
    end else if (state == ICT_ST_IDLE) begin
      start_req <= 1'b0;
    end
  end

  // Start sequencer: set-up count, drive SDA low, hold count, drive SCL low
  assign st_hit = (state == ICT_ST_SETUP && st_cnt == setup_sel) ||
                  (state == ICT_ST_HOLD && st_cnt == hold_sel);

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      state <= ICT_ST_IDLE;
      st_cnt <= 9'h000;
    end else begin
      case (state)
        ICT_ST_IDLE: begin
          if (start_req) begin
            state <= ICT_ST_WAIT_HIGH;
          end
        end
        ICT_ST_WAIT_HIGH: begin
          if (bus_idle) begin
            state <= ICT_ST_SETUP;
            st_cnt <= 9'h000;
          end
        end
        ICT_ST_SETUP: begin
          if (st_hit) begin
            state <= ICT_ST_HOLD;
            st_cnt <= 9'h000;
          end else begin
            st_cnt <= st_cnt + 9'h001;
          end
        end
        ICT_ST_HOLD: begin
          if (start_det) begin
            st_cnt <= 9'h000;
          end else if (st_hit) begin
            state <= ICT_ST_IDLE;
          end else begin
            st_cnt <= st_cnt + 9'h001;
          end
        end
        default: begin
          state <= ICT_ST_IDLE;
        end
      endcase
    end
  end

  // Hold count restarts once the start is seen on the bus; SCL is driven low only after that
  logic hold_armed;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      hold_armed <= 1'b0;
    end else if (state != ICT_ST_HOLD) begin
      hold_armed <= 1'b0;
    end else if (start_det) begin
      hold_armed <= 1'b1;
    end
  end

  // Pin drive; open drain so the driven level is always low
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      drive <= '0;
      O_START_DONE <= 1'b0;
    end else begin
      O_START_DONE <= 1'b0;
      case (state)
        ICT_ST_IDLE: begin
          if (start_req) begin
            drive <= '0;
          end else if (dh_hit && I_TX_EN) begin
            drive.sda_oe <= ~I_TX_BIT;
          end
        end
        ICT_ST_WAIT_HIGH: begin
          drive <= '0;
        end
        ICT_ST_SETUP: begin
          if (st_hit) begin
            drive.sda_oe <= 1'b1;
          end
        end
        ICT_ST_HOLD: begin
          if (st_hit && hold_armed && !start_det) begin
            drive.scl_oe <= 1'b1;
            O_START_DONE <= 1'b1;
          end
        end
        default: begin
          drive <= '0;
        end
      endcase
    end
  end

  assign O_SCL_OE = drive.scl_oe;
  assign O_SDA_OE = drive.sda_oe;

  always_ff @(posedge I_MCLK) begin
    O_SCL_O <= 1'b0;
    O_SDA_O <= 1'b0;
  end

  // Checks
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  property p_clr_tx_overrun;
    wr_clear && I_BUS.wdata[ICT_B_TX_OVERRUN] && !I_EVT[ICT_B_TX_OVERRUN]
      |=> !pending[ICT_B_TX_OVERRUN];
  endproperty
  a_clr_tx_overrun: assert property (p_clr_tx_overrun) else $error("tx overrun not cleared");
  property p_clr_rd_req;
    wr_clear && I_BUS.wdata[ICT_B_SLV_RD_REQ] && !I_EVT[ICT_B_SLV_RD_REQ]
      |=> !pending[ICT_B_SLV_RD_REQ];
  endproperty
  a_clr_rd_req: assert property (p_clr_rd_req) else $error("read req not cleared");
  property p_clr_rd_empty;
    wr_clear && I_BUS.wdata[ICT_B_SLV_RD_EMPTY] && !I_EVT[ICT_B_SLV_RD_EMPTY]
      |=> !pending[ICT_B_SLV_RD_EMPTY];
  endproperty
  a_clr_rd_empty: assert property (p_clr_rd_empty) else $error("read empty not cleared");
  property p_clr_wr_req;
    wr_clear && I_BUS.wdata[ICT_B_SLV_WR_REQ] && !I_EVT[ICT_B_SLV_WR_REQ]
      |=> !pending[ICT_B_SLV_WR_REQ];
  endproperty
  a_clr_wr_req: assert property (p_clr_wr_req) else $error("write req not cleared");
  property p_clr_mst_done;
    wr_clear && I_BUS.wdata[ICT_B_MST_DONE] && !I_EVT[ICT_B_MST_DONE]
      |=> !pending[ICT_B_MST_DONE];
  endproperty
  a_clr_mst_done: assert property (p_clr_mst_done) else $error("master done not cleared");
  property p_clr_slv_done;
    wr_clear && I_BUS.wdata[ICT_B_SLV_DONE] && !I_EVT[ICT_B_SLV_DONE]
      |=> !pending[ICT_B_SLV_DONE];
  endproperty
  a_clr_slv_done: assert property (p_clr_slv_done) else $error("slave done not cleared");
  property p_clr_arb;
    wr_clear && I_BUS.wdata[ICT_B_ARB_LOST] && !I_EVT[ICT_B_ARB_LOST]
      |=> !pending[ICT_B_ARB_LOST];
  endproperty
  a_clr_arb: assert property (p_clr_arb) else $error("arb lost not cleared");
  property p_clr_berr;
    wr_clear && I_BUS.wdata[ICT_B_BUS_ERR] && !I_EVT[ICT_B_BUS_ERR]
      |=> !pending[ICT_B_BUS_ERR];
  endproperty
  a_clr_berr: assert property (p_clr_berr) else $error("bus error not cleared");
  property p_clr_nostop;
    wr_clear && I_BUS.wdata[ICT_B_MST_NOSTOP] && !I_EVT[ICT_B_MST_NOSTOP]
      |=> !pending[ICT_B_MST_NOSTOP];
  endproperty
  a_clr_nostop: assert property (p_clr_nostop) else $error("nostop done not cleared");
  property p_pend_update;
    1'b1 |=> pending == (($past(pending) & ~$past(clr_bits)) | $past(evt_bits));
  endproperty
  a_pend_update: assert property (p_pend_update) else $error("pending bits wrong");
  sequence s_fall_launch;
    scl_fall ##1 (dh_run && dh_cnt == 9'h000);
  endsequence
  property p_dh_xfer;
    O_DATA_XFER |-> $past(dh_run) && $past(dh_cnt) == $past(data_hold_count);
  endproperty
  a_dh_xfer: assert property (p_dh_xfer) else $error("data moved before hold");
  property p_dh_launch;
    scl_fall |-> s_fall_launch;
  endproperty
  a_dh_launch: assert property (p_dh_launch) else $error("hold count not launched");
  property p_hold_std;
    $rose(O_SCL_OE) && !$past(I_FAST_MODE) |-> $past(st_cnt) == $past(start_hold_std_count);
  endproperty
  a_hold_std: assert property (p_hold_std) else $error("std start hold wrong");
  property p_hold_fst;
    $rose(O_SCL_OE) && $past(I_FAST_MODE) |-> $past(st_cnt) == $past(start_hold_fast_count);
  endproperty
  a_hold_fst: assert property (p_hold_fst) else $error("fast start hold wrong");
  property p_setup_std;
    $rose(O_SDA_OE) && $past(state) == ICT_ST_SETUP && !$past(I_FAST_MODE)
      |-> $past(st_cnt) == $past(start_setup_std_count);
  endproperty
  a_setup_std: assert property (p_setup_std) else $error("std setup wrong");
  property p_setup_fst;
    $rose(O_SDA_OE) && $past(state) == ICT_ST_SETUP && $past(I_FAST_MODE)
      |-> $past(st_cnt) == $past(start_setup_fast_count);
  endproperty
  a_setup_fst: assert property (p_setup_fst) else $error("fast setup wrong");
  // The line follows the status register as it now stands, masked as set a cycle ago
  property p_irq_level;
    1'b1 |=> O_IRQ == |(pending & $past(mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
endmodule
`default_nettype wire

/* File: sim/ict_peer.sv */
// I2C bus peer: clocks SCL for one-bit frames and resolves the open-drain wires
`timescale 1ns/100ps
`default_nettype none
module ict_peer #(
  parameter int HALF_NS = 40
) (
  // Frame request from the bench
  input wire logic i_go,
  // Device drive enables
  input wire logic i_scl_oe,
  input wire logic i_sda_oe,
  // Resolved line levels
  output logic o_scl,
  output logic o_sda
);
  logic peer_scl_oe;
  initial peer_scl_oe = 1'b0;
  // One low phase of an 80 ns SCL period, off the device clock's phase; still between frames
  always @(posedge i_go) begin
    #3;
    peer_scl_oe = 1'b1;
    #HALF_NS;
    peer_scl_oe = 1'b0;
  end
  // Pull-ups: a released line reads high
  assign o_scl = ~(peer_scl_oe | i_scl_oe);
  assign o_sda = ~i_sda_oe;
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the interrupt-clear and timing block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ict_pkg::*;
  logic mclk, rst, fast, tx_en, tx_bit, go, scl, sda;
  ict_bus_req_t bus;
  logic [31:0] evt, rdata, exp;
  logic o_data_xfer, o_start_done, o_irq, o_scl_o, o_scl_oe, o_sda_o, o_sda_oe;
  int n_mismatch = 0;
  int cmp_count = 0;
  int d5, d20, s_std, h_std, s_f, h_f;
  int bits[9] = '{ICT_B_TX_OVERRUN, ICT_B_SLV_RD_REQ, ICT_B_SLV_RD_EMPTY, ICT_B_SLV_WR_REQ,
                  ICT_B_MST_DONE, ICT_B_SLV_DONE, ICT_B_ARB_LOST, ICT_B_BUS_ERR,
                  ICT_B_MST_NOSTOP};

  ict_top i_ict_top (
    .I_MCLK(mclk), .I_RST(rst), .I_BUS(bus), .O_RDATA(rdata), .I_EVT(evt),
    .I_FAST_MODE(fast), .I_TX_EN(tx_en), .I_TX_BIT(tx_bit), .O_DATA_XFER(o_data_xfer),
    .O_START_DONE(o_start_done), .O_IRQ(o_irq), .I_SCL(scl), .I_SDA(sda),
    .O_SCL_O(o_scl_o), .O_SCL_OE(o_scl_oe), .O_SDA_O(o_sda_o), .O_SDA_OE(o_sda_oe)
  );

  ict_peer i_ict_peer (
    .i_go(go), .i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe), .o_scl(scl), .o_sda(sda)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
    cmp_count++;
    if (got !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, e, got);
    end
  endtask

  // Writes keep every reserved field at zero
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    chk(name, e, rdata);
  endtask

  task automatic wait_for(input int sel, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
      hit = (sel == 0) ? (o_data_xfer === 1'b1) :
            (sel == 1) ? (o_sda_oe === 1'b1) : (o_start_done === 1'b1);
    end
    if (!hit) begin
      n_mismatch++;
      $display("BAD wait_%0d expected 1 seen 0", sel);
    end
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
  endtask

  task automatic dh_run(output int n);
    @(posedge mclk);
    go <= 1'b1;
    wait_for(0, n);
    go <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask

  task automatic start_run(output int s, output int h);
    reg_wr(ICT_OFF_CTRL, 32'h0000_0001);
    wait_for(1, s);
    wait_for(2, h);
    chk("scl_oe", 32'h1, {31'h0, o_scl_oe});
    chk("scl_o", 32'h0, {31'h0, o_scl_o});
    chk("sda_o", 32'h0, {31'h0, o_sda_o});
    // The start request must have cleared itself once the sequence was taken
    rd_chk("ctrl", ICT_OFF_CTRL, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    bus = '0;
    evt = '0;
    fast = 1'b0;
    tx_en = 1'b0;
    tx_bit = 1'b0;
    go = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd_chk("data_hold_time", ICT_OFF_DATA_HOLD, 32'h0000_0014);
    rd_chk("start_hold_time", ICT_OFF_START_HOLD, 32'h003F_00E2);
    rd_chk("start_setup_time", ICT_OFF_START_SETUP, 32'h001D_00E2);
    rd_chk("irq_clear", ICT_OFF_IRQ_CLEAR, 32'h0);
    rd_chk("unmapped", 8'h10, 32'h0);
    reg_wr(ICT_OFF_DATA_HOLD, 32'h0000_01FF);
    rd_chk("data_hold_time", ICT_OFF_DATA_HOLD, 32'h0000_01FF);
    reg_wr(ICT_OFF_START_HOLD, 32'h0155_00AA);
    rd_chk("start_hold_time", ICT_OFF_START_HOLD, 32'h0155_00AA);
    reg_wr(ICT_OFF_START_SETUP, 32'h0133_0077);
    rd_chk("start_setup_time", ICT_OFF_START_SETUP, 32'h0133_0077);
    $display("test registers done");

    reg_wr(ICT_OFF_IRQ_MASK, 32'h0);
    @(posedge mclk);
    evt <= ICT_IRQ_BITS;
    @(posedge mclk);
    evt <= '0;
    repeat (3) @(posedge mclk);
    #1;
    chk("irq_masked", 32'h0, {31'h0, o_irq});
    exp = ICT_IRQ_BITS;
    reg_wr(ICT_OFF_IRQ_CLEAR, 32'h0);
    rd_chk("irq_status", ICT_OFF_IRQ_STATUS, exp);
    reg_wr(ICT_OFF_IRQ_MASK, ICT_IRQ_BITS);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq", 32'h1, {31'h0, o_irq});
    foreach (bits[k]) begin
      reg_wr(ICT_OFF_IRQ_CLEAR, 32'h1 << bits[k]);
      exp = exp & ~(32'h1 << bits[k]);
      // Only the written position may drop; its neighbours stay pending
      rd_chk("irq_status", ICT_OFF_IRQ_STATUS, exp);
      chk("irq", {31'h0, exp != 0}, {31'h0, o_irq});
    end
    rd_chk("irq_mask", ICT_OFF_IRQ_MASK, ICT_IRQ_BITS);
    // The status address clears by writing one as well
    @(posedge mclk);
    evt <= 32'h1 << ICT_B_MST_DONE;
    @(posedge mclk);
    evt <= '0;
    rd_chk("irq_status", ICT_OFF_IRQ_STATUS, 32'h1 << ICT_B_MST_DONE);
    reg_wr(ICT_OFF_IRQ_STATUS, 32'h1 << ICT_B_MST_DONE);
    rd_chk("irq_status", ICT_OFF_IRQ_STATUS, 32'h0);
    chk("irq", 32'h0, {31'h0, o_irq});
    $display("test interrupts done");

    // Two hold values through the same path: the synchroniser delay cancels in the difference
    @(posedge mclk);
    tx_en <= 1'b1;
    tx_bit <= 1'b0;
    reg_wr(ICT_OFF_DATA_HOLD, 32'd5);
    dh_run(d5);
    chk("sda_oe_low_bit", 32'h1, {31'h0, o_sda_oe});
    chk("hold_window", 32'h1, {31'h0, (d5 >= 8) && (d5 <= 13)});
    @(posedge mclk);
    tx_bit <= 1'b1;
    reg_wr(ICT_OFF_DATA_HOLD, 32'd20);
    dh_run(d20);
    chk("sda_oe_high_bit", 32'h0, {31'h0, o_sda_oe});
    chk("hold_delta", 32'd15, 32'(d20 - d5));
    $display("test data hold done");

    @(posedge mclk);
    tx_en <= 1'b0;
    do_reset();
    start_run(s_std, h_std);
    @(posedge mclk);
    fast <= 1'b1;
    do_reset();
    start_run(s_f, h_f);
    chk("setup_delta", 32'd197, 32'(s_std - s_f));
    chk("start_hold_delta", 32'd163, 32'(h_std - h_f));
    $display("test start sequence done");
    report_and_stop();
  end
endmodule
`default_nettype wire
